// >>> hdl/flash_status_pkg.sv
// Shared constants and types for the partition status reporting block
package flash_status_pkg;

   // Geometry
   localparam int PART_W      = 3;
   localparam int NPART       = 8;
   localparam int DATA_W      = 16;
   localparam int STAT_W      = 8;
   localparam int SYNC_STAGES = 3;

   // Command opcodes seen on the low data byte of a write
   localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
   localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_ID      = 8'h90;
   localparam logic [7:0] CMD_READ_QUERY   = 8'h98;
   localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
   localparam logic [7:0] CMD_PROG_ALT     = 8'h10;
   localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
   localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
   localparam logic [7:0] CMD_EFP_SETUP    = 8'h30;
   localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
   localparam logic [7:0] CMD_SUSPEND      = 8'hb0;

   // Field positions of the partition status word
   localparam int BIT_READY      = 7;
   localparam int BIT_ERASE_SUSP = 6;
   localparam int BIT_ERASE_ERR  = 5;
   localparam int BIT_PROG_FAIL  = 4;
   localparam int BIT_SUPPLY_LOW = 3;
   localparam int BIT_PROG_SUSP  = 2;
   localparam int BIT_LOCKED     = 1;
   localparam int BIT_PART_BUSY  = 0;

   // Upper data byte during a status read
   localparam logic [7:0] STATUS_UPPER = 8'h00;

   // Per-partition flags, bits 6 down to 1 of the status word
   typedef struct packed {
      logic erase_suspended_flag;
      logic erase_error_flag;
      logic program_fail_flag;
      logic supply_low_flag;
      logic program_suspended_flag;
      logic locked_block_abort_flag;
   } part_flags_t;

   // Reset values
   localparam part_flags_t        FLAGS_RST     = 6'h00;
   localparam logic [NPART-1:0]   STAT_MODE_RST = 8'h00;
   localparam logic [STAT_W-1:0]  RD_WORD_RST   = 8'h80;

   // Command sequencer states
   typedef enum logic [4:0] {
      SEQ_IDLE  = 5'b00001,
      SEQ_PROG  = 5'b00010,
      SEQ_ERASE = 5'b00100,
      SEQ_LOCK  = 5'b01000,
      SEQ_EFP   = 5'b10000
   } seq_state_t;

   typedef enum logic [1:0] {
      OP_PROGRAM = 2'h0,
      OP_ERASE   = 2'h1,
      OP_LOCK    = 2'h2,
      OP_EFP     = 2'h3
   } op_kind_t;

   // Host pins after synchronisation
   typedef struct packed {
      logic              adv_n;
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic              wp_n;
      logic [PART_W-1:0] addr_hi;
      logic [DATA_W-1:0] a_dq;
   } pin_in_t;

   localparam pin_in_t PIN_IDLE = 24'hf80000;

   // Write engine report, same clock
   typedef struct packed {
      logic              write_engine_busy;
      logic [PART_W-1:0] busy_part;
      logic              busy_is_erase;
      logic              efp_active;
      logic              efp_word_done;
      logic              op_done;
      logic              erase_fail;
      logic              program_fail;
      logic              supply_low;
      logic              locked_target;
   } engine_in_t;

   // Requests to the write engine
   typedef struct packed {
      logic              start;
      op_kind_t          kind;
      logic [PART_W-1:0] part;
      logic [DATA_W-1:0] data;
      logic              suspend;
      logic              resume;
      logic              abort;
   } engine_req_t;

   localparam engine_req_t REQ_IDLE = '0;

endpackage

// >>> hdl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pin_sync
   import flash_status_pkg::*;
#(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sync_t;

   sync_t st;
   sync_t next_st;

   // Output moves only once stages two and three agree; stage one feeds stage two alone
   always_comb begin
      next_st    = st;
      next_st.s1 = d;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < W; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.q[i] = st.s3[i];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
      end else begin
         st <= next_st;
      end
   end

   assign q = st.q;

endmodule // pin_sync
`default_nettype wire

// >>> hdl/flash_partition_status_reporting.sv
// Per-partition status words served over the multiplexed address/data bus
// How it works
// - Status-read command to any partition address puts that partition in status mode.
// - Program, erase or lock setup leaves the addressed partition in status mode.
// - Reads of a partition in status mode return status until a read-array, ID or query command.
// - Only single reads are served; host issues no bursts in status mode.
// - Falling edge of output or chip enable, whichever comes last, captures a fresh status.
// - Entering status mode touches no other partition's read mode.
// - Status on low byte, zeros on the upper data byte.
// - Bits 6..0 per partition; bit 7 shows whole-device engine activity.
// - Bit 7 low while engine busy, high when ready.
// - While busy, bit 0 low for the busy partition, high for others.
// - Ready with bit 0 clear means idle; bits 7 and 0 never both set outside fast factory write.
// - Erase suspend halts engine, sets bit 6 until erase resume.
// - Program suspend halts engine, sets bit 2 until resume.
// - Failed erase sets bit 5.
// - Improper command sequence sets bits 5 and 4 with engine ready.
// - Failed word program sets bit 4.
// - Bit 3 records low supply, sampled only at operation completion.
// - Program or erase to locked block under write protect sets bit 1, aborts.
// - In fast factory write, bit 0 flags a streamed word finished.
// - Status-clear clears error flags 5,4,3,1, keeps suspend flags and read modes, ignores supply level.
// - Error bits 5,4,3,1 accumulate until status-clear.
// - Reset clears the status of every partition.
// - First write of a two-cycle command switches the partition to status mode.
`timescale 1ns/100ps
`default_nettype none
module flash_partition_status_reporting
   import flash_status_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              adv_n,
   input  wire logic              ce_n,
   input  wire logic              oe_n,
   input  wire logic              we_n,
   input  wire logic              wp_n,
   input  wire logic [PART_W-1:0] addr_hi,
   input  wire logic [DATA_W-1:0] a_dq_in,
   output logic      [DATA_W-1:0] a_dq_out,
   output logic                   a_dq_oe,
   input  wire engine_in_t        engine,
   output engine_req_t            engine_req,
   output logic                   addr_status_mode
);

   typedef struct packed {
      seq_state_t                     seq;
      logic [PART_W-1:0]              seq_part;
      logic [NPART-1:0]               stat_mode;
      part_flags_t [NPART-1:0]        flags;
      logic [PART_W-1:0]              addr_part;
      logic [STAT_W-1:0]              rd_word;
      logic                           rd_act_q;
      logic                           prev_we_n;
      logic                           drive;
      engine_req_t                    req;
   } state_t;

   state_t  st;
   state_t  next_st;
   pin_in_t pin_raw;
   pin_in_t pin;
   logic    wr_fire;
   logic    rd_act;
   logic    rd_start;
   logic    clear_fire;
   logic [7:0] wr_byte;
   logic [NPART*4-1:0] err_vec;

   // Host pins come from another clock domain
   assign pin_raw = '{adv_n: adv_n, ce_n: ce_n, oe_n: oe_n, we_n: we_n, wp_n: wp_n,
                      addr_hi: addr_hi, a_dq: a_dq_in};

   pin_sync #(
      .W       ($bits(pin_in_t)),
      .RST_VAL (PIN_IDLE)
   ) u_pin_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .d       (pin_raw),
      .q       (pin)
   );

   // Status word for one partition as seen by a reader of that partition
   function automatic logic [STAT_W-1:0] status_word(input part_flags_t f,
                                                     input logic [PART_W-1:0] p,
                                                     input engine_in_t e);
      logic [STAT_W-1:0] w;
      w                 = '0;
      w[BIT_READY]      = ~e.write_engine_busy;
      w[BIT_ERASE_SUSP] = f.erase_suspended_flag;
      w[BIT_ERASE_ERR]  = f.erase_error_flag;
      w[BIT_PROG_FAIL]  = f.program_fail_flag;
      w[BIT_SUPPLY_LOW] = f.supply_low_flag;
      w[BIT_PROG_SUSP]  = f.program_suspended_flag;
      w[BIT_LOCKED]     = f.locked_block_abort_flag;
      if (e.efp_active) begin
         w[BIT_PART_BUSY] = e.efp_word_done;
      end else if (e.write_engine_busy) begin
         w[BIT_PART_BUSY] = (e.busy_part != p);
      end else begin
         w[BIT_PART_BUSY] = 1'b0;
      end
      return w;
   endfunction

   // Bus strobes: a write completes on the rising edge of write enable
   assign wr_fire = ~st.prev_we_n & pin.we_n & ~pin.ce_n;
   assign wr_byte = pin.a_dq[7:0];
   assign rd_act  = ~pin.ce_n & ~pin.oe_n & pin.we_n;
   assign rd_start = rd_act & ~st.rd_act_q;
   assign clear_fire = wr_fire && (st.seq == SEQ_IDLE) && (wr_byte == CMD_CLEAR_STATUS);

   always_comb begin
      next_st           = st;
      next_st.req       = REQ_IDLE;
      next_st.req.kind  = st.req.kind;
      next_st.req.part  = st.req.part;
      next_st.req.data  = st.req.data;
      next_st.prev_we_n = pin.we_n;
      next_st.rd_act_q  = rd_act;

      // Address phase of the multiplexed bus picks the partition
      if (~pin.adv_n & ~pin.ce_n) begin
         next_st.addr_part = pin.addr_hi;
      end

      // Clear first, so an event in the same cycle still sets its flag
      if (clear_fire) begin
         for (int p = 0; p < NPART; p++) begin
            next_st.flags[p].erase_error_flag        = 1'b0;
            next_st.flags[p].program_fail_flag       = 1'b0;
            next_st.flags[p].supply_low_flag         = 1'b0;
            next_st.flags[p].locked_block_abort_flag = 1'b0;
         end
      end

      // Command decode; mode changes only ever touch the written partition
      if (wr_fire) begin
         case (st.seq)
            SEQ_IDLE: begin
               case (wr_byte)
                  CMD_READ_STATUS: begin
                     next_st.stat_mode[st.addr_part] = 1'b1;
                  end
                  CMD_READ_ARRAY, CMD_READ_ID, CMD_READ_QUERY: begin
                     next_st.stat_mode[st.addr_part] = 1'b0;
                  end
                  CMD_PROG_SETUP, CMD_PROG_ALT: begin
                     next_st.seq                     = SEQ_PROG;
                     next_st.seq_part                = st.addr_part;
                     next_st.stat_mode[st.addr_part] = 1'b1;
                  end
                  CMD_ERASE_SETUP: begin
                     next_st.seq                     = SEQ_ERASE;
                     next_st.seq_part                = st.addr_part;
                     next_st.stat_mode[st.addr_part] = 1'b1;
                  end
                  CMD_LOCK_SETUP: begin
                     next_st.seq                     = SEQ_LOCK;
                     next_st.seq_part                = st.addr_part;
                     next_st.stat_mode[st.addr_part] = 1'b1;
                  end
                  CMD_EFP_SETUP: begin
                     next_st.seq                     = SEQ_EFP;
                     next_st.seq_part                = st.addr_part;
                     next_st.stat_mode[st.addr_part] = 1'b1;
                  end
                  CMD_SUSPEND: begin
                     // Fast factory writes cannot be suspended
                     if (engine.write_engine_busy && !engine.efp_active) begin
                        next_st.req.suspend = 1'b1;
                        if (engine.busy_is_erase) begin
                           next_st.flags[engine.busy_part].erase_suspended_flag = 1'b1;
                        end else begin
                           next_st.flags[engine.busy_part].program_suspended_flag = 1'b1;
                        end
                     end
                  end
                  CMD_CONFIRM: begin
                     // Resume the innermost suspend first
                     if (st.flags[st.addr_part].program_suspended_flag) begin
                        next_st.flags[st.addr_part].program_suspended_flag = 1'b0;
                        next_st.req.resume = 1'b1;
                     end else if (st.flags[st.addr_part].erase_suspended_flag) begin
                        next_st.flags[st.addr_part].erase_suspended_flag = 1'b0;
                        next_st.req.resume = 1'b1;
                     end
                  end
                  default: begin
                  end
               endcase
            end
            SEQ_PROG, SEQ_LOCK: begin
               // Second cycle carries the data word or lock code
               next_st.seq       = SEQ_IDLE;
               next_st.req.start = 1'b1;
               next_st.req.kind  = (st.seq == SEQ_PROG) ? OP_PROGRAM : OP_LOCK;
               next_st.req.part  = st.seq_part;
               next_st.req.data  = pin.a_dq;
            end
            SEQ_ERASE, SEQ_EFP: begin
               next_st.seq = SEQ_IDLE;
               if (wr_byte == CMD_CONFIRM) begin
                  next_st.req.start = 1'b1;
                  next_st.req.kind  = (st.seq == SEQ_ERASE) ? OP_ERASE : OP_EFP;
                  next_st.req.part  = st.seq_part;
                  next_st.req.data  = pin.a_dq;
               end else begin
                  next_st.flags[st.seq_part].erase_error_flag  = 1'b1;
                  next_st.flags[st.seq_part].program_fail_flag = 1'b1;
               end
            end
            default: begin
               next_st.seq = SEQ_IDLE;
            end
         endcase
      end

      // Engine reports land on the busy partition and only ever set error flags
      if (engine.erase_fail) begin
         next_st.flags[engine.busy_part].erase_error_flag = 1'b1;
      end
      if (engine.program_fail) begin
         next_st.flags[engine.busy_part].program_fail_flag = 1'b1;
      end
      if (engine.op_done && engine.supply_low) begin
         next_st.flags[engine.busy_part].supply_low_flag = 1'b1;
      end
      if (engine.locked_target && !pin.wp_n) begin
         next_st.flags[engine.busy_part].locked_block_abort_flag = 1'b1;
         next_st.req.abort = 1'b1;
      end

      // Latch the word when the later of the two strobes falls; bursts get no increment
      if (rd_start) begin
         next_st.rd_word = status_word(st.flags[st.addr_part], st.addr_part, engine);
      end
      next_st.drive = rd_act & st.stat_mode[st.addr_part];
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st.seq       <= SEQ_IDLE;
         st.seq_part  <= '0;
         st.stat_mode <= STAT_MODE_RST;
         st.flags     <= {NPART{FLAGS_RST}};
         st.addr_part <= '0;
         st.rd_word   <= RD_WORD_RST;
         st.rd_act_q  <= 1'b0;
         st.prev_we_n <= 1'b1;
         st.drive     <= 1'b0;
         st.req       <= REQ_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // Outputs: upper byte stays zero during status reads
   assign a_dq_out         = {STATUS_UPPER, st.rd_word};
   assign a_dq_oe          = st.drive;
   assign engine_req       = st.req;
   assign addr_status_mode = st.stat_mode[st.addr_part];

   // Error bits of every partition, for checking only
   always_comb begin
      err_vec = '0;
      for (int p = 0; p < NPART; p++) begin
         err_vec[p*4 +: 4] = {st.flags[p].erase_error_flag, st.flags[p].program_fail_flag,
                              st.flags[p].supply_low_flag, st.flags[p].locked_block_abort_flag};
      end
   end

   sequence status_cmd_s;
      wr_fire && st.seq == SEQ_IDLE && wr_byte == CMD_READ_STATUS;
   endsequence

   sequence erase_setup_s;
      wr_fire && st.seq == SEQ_IDLE && wr_byte == CMD_ERASE_SETUP;
   endsequence

   sequence bad_confirm_s;
      wr_fire && st.seq == SEQ_ERASE && wr_byte != CMD_CONFIRM;
   endsequence

   chk_status_entry: assert property (@(posedge clk_sys) disable iff (rst)
      status_cmd_s |=> st.stat_mode[$past(st.addr_part)])
      else $error("status command did not enter status mode");

   chk_other_modes: assert property (@(posedge clk_sys) disable iff (rst)
      status_cmd_s |=> ((st.stat_mode | (8'h01 << $past(st.addr_part)))
                        == ($past(st.stat_mode) | (8'h01 << $past(st.addr_part)))))
      else $error("status command changed another partition mode");

   chk_setup_mode: assert property (@(posedge clk_sys) disable iff (rst)
      erase_setup_s |=> st.stat_mode[$past(st.addr_part)] && st.seq == SEQ_ERASE)
      else $error("setup write did not enter status mode");

   chk_seq_error: assert property (@(posedge clk_sys) disable iff (rst)
      erase_setup_s ##[1:100] bad_confirm_s |=> st.flags[$past(st.seq_part)].erase_error_flag
                                          && st.flags[$past(st.seq_part)].program_fail_flag)
      else $error("improper sequence not flagged");

   chk_ready_bit: assert property (@(posedge clk_sys) disable iff (rst)
      rd_start |=> st.rd_word[BIT_READY] == !$past(engine.write_engine_busy))
      else $error("ready bit does not follow engine");

   chk_no_both_set: assert property (@(posedge clk_sys) disable iff (rst)
      rd_start && !engine.efp_active |=> !(st.rd_word[BIT_READY] && st.rd_word[BIT_PART_BUSY]))
      else $error("ready and partition busy both set");

   chk_error_sticky: assert property (@(posedge clk_sys) disable iff (rst)
      !clear_fire |=> ((err_vec & $past(err_vec)) == $past(err_vec)))
      else $error("error flag dropped without status clear");

   chk_reset_clear: assert property (@(posedge clk_sys)
      rst |=> err_vec == '0 && st.rd_word == RD_WORD_RST && !a_dq_oe)
      else $error("reset left status flags set");

   chk_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
      a_dq_oe |-> a_dq_out[15:8] == STATUS_UPPER && $past(rd_act, 1))
      else $error("status read drove upper byte or drove without a read");

endmodule // flash_partition_status_reporting
`default_nettype wire

// >>> test/bus_host_model.sv
// Host controller model driving the multiplexed address/data pins
`timescale 1ns/100ps
`default_nettype none
module bus_host_model
   import flash_status_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic [DATA_W-1:0] a_dq_out,
   input  wire logic              a_dq_oe,
   output logic                   adv_n,
   output logic                   ce_n,
   output logic                   oe_n,
   output logic                   we_n,
   output logic [PART_W-1:0]      addr_hi,
   output logic [DATA_W-1:0]      a_dq_in
);
   // Idle pin levels from time zero
   initial begin
      adv_n = 1'b1;
      ce_n = 1'b1;
      oe_n = 1'b1;
      we_n = 1'b1;
      addr_hi = 3'h0;
      a_dq_in = 16'h0000;
   end

   // Each phase is held at least five cycles so the pin filter sees it
   task automatic hold(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Address phase, with the bus word already at the given value
   task automatic select(input logic [PART_W-1:0] p, input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      adv_n <= 1'b0;
      ce_n <= 1'b0;
      addr_hi <= p;
      a_dq_in <= d;
      hold(5);
      adv_n <= 1'b1;
   endtask

   // One command write cycle to any address of a partition
   task automatic wr(input logic [PART_W-1:0] p, input logic [7:0] cmd);
      select(p, {8'h00, cmd});
      we_n <= 1'b0;
      hold(5);
      we_n <= 1'b1;
      hold(5);
      ce_n <= 1'b1;
      a_dq_in <= ~a_dq_in; // Released bus, no stale value
      hold(5);
   endtask

   // Single read, one access per chip-enable cycle, never a burst
   task automatic rd(input logic [PART_W-1:0] p, output logic seen, output logic [15:0] d);
      select(p, 16'h5a5a);
      a_dq_in <= 16'ha5a5;
      oe_n <= 1'b0;
      for (int i = 0; i < 12 && a_dq_oe !== 1'b1; i++) @(negedge clk_sys);
      seen = a_dq_oe;
      d = a_dq_out;
      @(posedge clk_sys);
      oe_n <= 1'b1;
      ce_n <= 1'b1;
      hold(6);
   endtask
endmodule // bus_host_model
`default_nettype wire

// >>> test/flash_partition_status_reporting_tb.sv
// Self-checking bench for the partition status reporting block
`timescale 1ns/100ps
`default_nettype none
module flash_partition_status_reporting_tb
   import flash_status_pkg::*;
;
   logic              clk_sys = 1'b0;
   logic              rst = 1'b1;
   logic              wp_n = 1'b1;
   engine_in_t        engine = '0;
   logic              adv_n, ce_n, oe_n, we_n, a_dq_oe, addr_status_mode;
   logic [PART_W-1:0] addr_hi;
   logic [DATA_W-1:0] a_dq_in, a_dq_out;
   engine_req_t       engine_req;
   int                n_susp = 0;
   int                n_res = 0;
   int                n_start = 0;
   int                n_abort = 0;
   int                err_total = 0;
   int                num_checks = 0;

   always #5 clk_sys = ~clk_sys;

   flash_partition_status_reporting flash_partition_status_reporting_i (
      .clk_sys(clk_sys), .rst(rst), .adv_n(adv_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .wp_n(wp_n), .addr_hi(addr_hi), .a_dq_in(a_dq_in), .a_dq_out(a_dq_out),
      .a_dq_oe(a_dq_oe), .engine(engine), .engine_req(engine_req),
      .addr_status_mode(addr_status_mode));

   bus_host_model bus_host_model_i (
      .clk_sys(clk_sys), .a_dq_out(a_dq_out), .a_dq_oe(a_dq_oe), .adv_n(adv_n),
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr_hi(addr_hi), .a_dq_in(a_dq_in));

   // Counts of the one-cycle engine requests; a stuck pulse shows as an extra count
   always @(posedge clk_sys) begin
      if (engine_req.suspend === 1'b1) n_susp <= n_susp + 1;
      if (engine_req.resume === 1'b1) n_res <= n_res + 1;
      if (engine_req.start === 1'b1) n_start <= n_start + 1;
      if (engine_req.abort === 1'b1) n_abort <= n_abort + 1;
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Read a partition and judge drive and word, upper byte included
   task automatic rd_chk(input logic [2:0] p, input logic exp_oe, input logic [7:0] exp);
      logic        seen;
      logic [15:0] d;
      bus_host_model_i.rd(p, seen, d);
      chk("drive", {15'h0000, exp_oe}, {15'h0000, seen});
      chk("mode", {15'h0000, exp_oe}, {15'h0000, addr_status_mode});
      if (exp_oe) chk("status", {STATUS_UPPER, exp}, d);
   endtask

   // Engine report for one cycle, then its pulses and sampled level drop
   task automatic ev(input logic [11:0] e);
      @(posedge clk_sys);
      engine <= engine_in_t'(e);
      @(posedge clk_sys);
      engine <= engine_in_t'(e & ~12'h01f);
      repeat (3) @(posedge clk_sys);
   endtask

   task automatic t_idle();
      rd_chk(3'd0, 1'b0, 8'h00);
      bus_host_model_i.wr(3'd2, CMD_READ_STATUS);
      rd_chk(3'd2, 1'b1, RD_WORD_RST);
      rd_chk(3'd2, 1'b1, RD_WORD_RST);
      rd_chk(3'd3, 1'b0, 8'h00);
      $display("test idle done");
   endtask

   task automatic t_busy();
      ev({1'b1, 3'd2, 8'h00});
      rd_chk(3'd2, 1'b1, 8'h00);
      bus_host_model_i.wr(3'd5, CMD_READ_STATUS);
      rd_chk(3'd5, 1'b1, 8'h01);
      ev({1'b1, 3'd2, 8'h18});
      ev(12'h000);
      rd_chk(3'd2, 1'b1, 8'ha0);
      rd_chk(3'd5, 1'b1, 8'h80);
      ev({1'b1, 3'd2, 8'h60});
      rd_chk(3'd2, 1'b1, 8'h21);
      ev(12'h000);
      $display("test busy done");
   endtask

   task automatic t_accum();
      int a0;
      ev({1'b1, 3'd2, 8'h16});
      wp_n <= 1'b0;
      // Write protect crosses the pin filter before the locked event arrives
      repeat (5) @(posedge clk_sys);
      a0 = n_abort;
      ev({1'b1, 3'd2, 8'h11});
      chk("abort req", 16'h0001, {15'h0000, n_abort == a0 + 1});
      ev(12'h000);
      wp_n <= 1'b1;
      rd_chk(3'd2, 1'b1, 8'hba);
      bus_host_model_i.wr(3'd2, CMD_CLEAR_STATUS);
      rd_chk(3'd2, 1'b1, 8'h80);
      $display("test accumulate done");
   endtask

   task automatic t_seq();
      int n0;
      bus_host_model_i.wr(3'd4, CMD_ERASE_SETUP);
      rd_chk(3'd4, 1'b1, 8'h80);
      bus_host_model_i.wr(3'd4, CMD_READ_ARRAY);
      rd_chk(3'd4, 1'b1, 8'hb0);
      bus_host_model_i.wr(3'd4, CMD_CLEAR_STATUS);
      rd_chk(3'd4, 1'b1, 8'h80);
      bus_host_model_i.wr(3'd3, CMD_EFP_SETUP);
      rd_chk(3'd3, 1'b1, 8'h80);
      n0 = n_start;
      bus_host_model_i.wr(3'd3, CMD_CONFIRM);
      chk("start count", 16'h0001, {15'h0000, n_start == n0 + 1});
      chk("start kind", {14'h0000, OP_EFP}, {14'h0000, engine_req.kind});
      chk("start part", 16'h0003, {13'h0000, engine_req.part});
      chk("start data", {8'h00, CMD_CONFIRM}, engine_req.data);
      $display("test sequence done");
   endtask

   // Suspend of an erase or a program on partition 1, then resume
   task automatic t_susp(input logic er, input logic [7:0] exp);
      int s0;
      int r0;
      s0 = n_susp;
      r0 = n_res;
      ev({1'b1, 3'd1, er, 7'h00});
      bus_host_model_i.wr(3'd1, CMD_SUSPEND);
      chk("suspend req", 16'h0001, {15'h0000, n_susp == s0 + 1});
      ev(12'h000);
      bus_host_model_i.wr(3'd1, CMD_READ_STATUS);
      rd_chk(3'd1, 1'b1, exp);
      rd_chk(3'd1, 1'b1, exp);
      bus_host_model_i.wr(3'd1, CMD_CONFIRM);
      chk("resume req", 16'h0001, {15'h0000, n_res == r0 + 1});
      bus_host_model_i.wr(3'd1, CMD_READ_STATUS);
      rd_chk(3'd1, 1'b1, 8'h80);
      $display("test suspend done");
   endtask

   task automatic t_reset();
      bus_host_model_i.wr(3'd6, CMD_ERASE_SETUP);
      bus_host_model_i.wr(3'd6, CMD_READ_ARRAY);
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      rd_chk(3'd6, 1'b0, 8'h00);
      bus_host_model_i.wr(3'd6, CMD_READ_STATUS);
      rd_chk(3'd6, 1'b1, 8'h80);
      $display("test reset done");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Main sequence after a 20-cycle reset
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      t_idle();
      t_busy();
      t_accum();
      t_seq();
      t_susp(1'b1, 8'hc0);
      t_susp(1'b0, 8'h84);
      t_reset();
      results();
   end

   // Watchdog, about forty times the expected run
   initial begin
      #400000;
      err_total++;
      results();
   end
endmodule // flash_partition_status_reporting_tb
`default_nettype wire
